// *** rtcs_params.svh ***
// Constants for the two-wire clock/calendar slave
`ifndef RTCS_PARAMS_SVH
`define RTCS_PARAMS_SVH

// Timing: one calendar second counted in system clocks
`define RTCS_SEC_NS 1000000000
`define RTCS_CLK_NS 20
`define RTCS_SEC_CYCLES (`RTCS_SEC_NS / `RTCS_CLK_NS)

// Serial framing
`define RTCS_LAST_BIT 4'h7
`define RTCS_ACK_BIT 4'h8

// Register space: calendar registers first, then user RAM
`define RTCS_CAL_REGS 6'h08
`define RTCS_CAL_COUNT 8
`define RTCS_RAM_WORDS 56

// Calendar register indexes
`define RTCS_REG_SEC 3'h0
`define RTCS_REG_MIN 3'h1
`define RTCS_REG_HOUR 3'h2
`define RTCS_REG_DAY 3'h3
`define RTCS_REG_DATE 3'h4
`define RTCS_REG_MONTH 3'h5
`define RTCS_REG_YEAR 3'h6
`define RTCS_REG_CTRL 3'h7

// Field masks and flag bits
`define RTCS_HALT_MASK 8'h80
`define RTCS_SEC_MASK 8'h7f
`define RTCS_MIN_MASK 8'h7f
`define RTCS_H24_MASK 8'h3f
`define RTCS_H12_MASK 8'h1f
`define RTCS_PM_MASK 8'h20
`define RTCS_MODE12_BIT 6
`define RTCS_DAY_MASK 8'h07
`define RTCS_DATE_MASK 8'h3f
`define RTCS_MONTH_MASK 8'h1f

// BCD limits
`define RTCS_BCD_ZERO 8'h00
`define RTCS_BCD_ONE 8'h01
`define RTCS_MAX_SEC 8'h59
`define RTCS_MAX_H24 8'h23
`define RTCS_H12_ELEVEN 8'h11
`define RTCS_H12_TWELVE 8'h12
`define RTCS_MAX_DAY 8'h07
`define RTCS_DAYS_FEB 8'h28
`define RTCS_DAYS_LEAP 8'h29
`define RTCS_DAYS_SHORT 8'h30
`define RTCS_DAYS_LONG 8'h31
`define RTCS_MON_FEB 8'h02
`define RTCS_MON_APR 8'h04
`define RTCS_MON_JUN 8'h06
`define RTCS_MON_SEP 8'h09
`define RTCS_MON_NOV 8'h11
`define RTCS_MAX_MONTH 8'h12
`define RTCS_MAX_YEAR 8'h99

`endif

// *** rtcs_pkg.sv ***
// Types shared by the two-wire clock/calendar slave
package rtcs_pkg;

  // Protocol states of the slave
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_WDATA,
    ST_RDATA
  } rtcs_state_t;

  // One bit sampled at the link, with its event toggle
  typedef struct packed {
    logic level;
    logic toggle;
  } rtcs_bit_t;

  // Register write port
  typedef struct packed {
    logic en;
    logic [5:0] addr;
    logic [7:0] data;
  } rtcs_wr_t;

endpackage

// *** rtcs_link.sv ***
// Bit sampler clocked by the bus clock line
`timescale 1ns/10ps
`default_nettype none

module rtcs_link (
  // Bus clock and reset
  input wire logic scl_clk,
  input wire logic rst_n,
  // Data line in, sampled bit out
  input wire logic sda,
  output var rtcs_pkg::rtcs_bit_t bit_o
);

  // Sample data on the rising clock edge; toggle marks a new bit
  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_o <= '0;
    end else begin
      bit_o.level <= sda;
      bit_o.toggle <= ~bit_o.toggle;
    end
  end

endmodule

`default_nettype wire

// *** rtcs_ram.sv ***
// User RAM with registered read data
`timescale 1ns/10ps
`default_nettype none
`include "rtcs_params.svh"

module rtcs_ram (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic wr_en,
  input wire logic [5:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read port
  input wire logic [5:0] rd_addr,
  output logic [7:0] rd_data
);

  logic [7:0] mem_r [`RTCS_RAM_WORDS];

  // Storage write
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Registered read, one cycle behind the address
  always_ff @(posedge clk) begin
    rd_data <= mem_r[rd_addr];
  end

endmodule

`default_nettype wire

// *** rtcs_slave.sv ***
// Two-wire slave with register pointer, calendar registers and user RAM
`timescale 1ns/10ps
`default_nettype none
`include "rtcs_params.svh"

// How it works
// RQ1 - Data changes only while clock is low
// RQ2 - Data falling with clock high starts transfer
// RQ3 - Data rising with clock high ends transfer
// RQ4 - One clock pulse per bit, sampled high
// RQ5 - Bytes plus ninth acknowledge bit, unlimited count
// RQ6 - Master makes all clocks and conditions
// RQ7 - Acknowledger holds data low through pulse
// RQ8 - Master acknowledges all but last read
// RQ9 - After not-acknowledge, slave releases data line
// RQ10 - Every byte shifted most significant bit first
// RQ11 - First byte: address plus direction bit
// RQ12 - Matching address acknowledged on ninth clock
// RQ13 - First written byte loads register pointer
// RQ14 - Later written bytes acknowledged and stored
// RQ15 - Pointer advances after every data byte
// RQ16 - Reads start at current pointer value
// RQ17 - Repeated start restarts, bus stays busy
// RQ18 - BCD time fields plus user RAM
// RQ19 - Month end and leap year wrap
// RQ20 - Selectable 12 or 24 hour mode
// RQ21 - Wrong address: no acknowledge, idle

module rtcs_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2a, // Arbitrary value
  parameter int unsigned SEC_CYCLES = `RTCS_SEC_CYCLES
) (
  // System clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // Two-wire bus, clock line is the link clock
  input wire logic SCL_CLK,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // Status
  output logic BUS_BUSY
);

  // BCD increment of one two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Step a BCD field, wrapping from top to low
  function automatic logic [7:0] bcd_step(input logic [7:0] v, input logic [7:0] top,
                                          input logic [7:0] low);
    bcd_step = (v == top) ? low : bcd_inc(v);
  endfunction

  // Last date of the month; BCD year divisible by four means leap
  function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = !yr[0] && (yr[1] == yr[4]);
    if (mon == `RTCS_MON_FEB) begin
      month_days = leap ? `RTCS_DAYS_LEAP : `RTCS_DAYS_FEB;
    end else if (mon == `RTCS_MON_APR || mon == `RTCS_MON_JUN ||
                 mon == `RTCS_MON_SEP || mon == `RTCS_MON_NOV) begin
      month_days = `RTCS_DAYS_SHORT;
    end else begin
      month_days = `RTCS_DAYS_LONG;
    end
  endfunction

  // Pointer decode: calendar register or user RAM
  function automatic logic is_cal(input logic [5:0] p);
    is_cal = p < `RTCS_CAL_REGS;
  endfunction

  // Link-side sampler
  rtcs_pkg::rtcs_bit_t link_bit;

  rtcs_link u_link (
    .scl_clk(SCL_CLK),
    .rst_n(RESETN),
    .sda(SDA_I),
    .bit_o(link_bit)
  );

  // Synchronisers and their delayed copies
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic [1:0] tgl_sync_r;
  logic scl_d_r;
  logic sda_d_r;
  logic tgl_d_r;

  // Protocol state
  rtcs_pkg::rtcs_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic rw_r;
  logic [5:0] ptr_r;
  rtcs_pkg::rtcs_wr_t wr_r;
  logic sda_oe_r;
  logic sda_o_r;
  logic busy_r;

  // Calendar state
  logic [7:0] cal_r [`RTCS_CAL_COUNT];
  logic [7:0] cal_nxt [`RTCS_CAL_COUNT];
  logic [31:0] sub_cnt_r;
  logic tick;

  // Derived events and data
  logic start_ev;
  logic stop_ev;
  logic fall_ev;
  logic bit_ev;
  logic rx_bit;
  logic [7:0] rx_byte;
  logic byte_done;
  logic ack_slot;
  logic [7:0] ram_q;
  logic [7:0] rd_byte;
  logic [5:0] ram_rd_addr;

  // Two flops on every pin and on the bit toggle from the link domain
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      scl_sync_r <= '1;
      sda_sync_r <= '1;
      tgl_sync_r <= '0;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      tgl_d_r <= 1'b0;
    end else begin
      scl_sync_r <= {scl_sync_r[0], SCL_CLK};
      sda_sync_r <= {sda_sync_r[0], SDA_I};
      tgl_sync_r <= {tgl_sync_r[0], link_bit.toggle};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
      tgl_d_r <= tgl_sync_r[1];
    end
  end

  // Bus conditions: data edges while the clock is high
  assign start_ev = scl_sync_r[1] && scl_d_r && sda_d_r && !sda_sync_r[1]; // [RQ2] [RQ1]
  assign stop_ev = scl_sync_r[1] && scl_d_r && !sda_d_r && sda_sync_r[1]; // [RQ3] [RQ1]
  assign fall_ev = scl_d_r && !scl_sync_r[1];
  // Bit level is stable long before its toggle is seen here
  assign bit_ev = tgl_sync_r[1] != tgl_d_r; // [RQ4]
  assign rx_bit = link_bit.level;
  assign rx_byte = {shift_r[6:0], rx_bit}; // [RQ10]
  assign byte_done = bit_ev && (cnt_r == `RTCS_LAST_BIT);
  assign ack_slot = bit_ev && (cnt_r == `RTCS_ACK_BIT); // [RQ5]

  // Frame state: condition detection wins over bit events
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_r <= rtcs_pkg::ST_IDLE;
      cnt_r <= '0;
      rw_r <= 1'b0;
    end else if (start_ev) begin
      state_r <= rtcs_pkg::ST_ADDR; // [RQ2] [RQ17]
      cnt_r <= '0;
    end else if (stop_ev) begin
      state_r <= rtcs_pkg::ST_IDLE; // [RQ3]
      cnt_r <= '0;
    end else if (bit_ev && state_r != rtcs_pkg::ST_IDLE) begin
      if (!ack_slot) begin
        cnt_r <= cnt_r + 4'h1;
        if (byte_done && state_r == rtcs_pkg::ST_ADDR) begin
          rw_r <= rx_byte[0]; // [RQ11]
          if (rx_byte[7:1] != DEV_ADDR) begin
            state_r <= rtcs_pkg::ST_IDLE; // [RQ21]
          end
        end
      end else begin
        cnt_r <= '0;
        unique case (state_r)
          rtcs_pkg::ST_ADDR: begin
            state_r <= rw_r ? rtcs_pkg::ST_RDATA : rtcs_pkg::ST_PTR; // [RQ11]
          end
          rtcs_pkg::ST_PTR: begin
            state_r <= rtcs_pkg::ST_WDATA;
          end
          rtcs_pkg::ST_WDATA: begin
            state_r <= rtcs_pkg::ST_WDATA; // [RQ14]
          end
          rtcs_pkg::ST_RDATA: begin
            // Not-acknowledge from the master ends sending
            if (rx_bit) begin
              state_r <= rtcs_pkg::ST_IDLE; // [RQ8] [RQ9]
            end
          end
          rtcs_pkg::ST_IDLE: begin
            state_r <= rtcs_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // Receive shifter, first bit lands in the top
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      shift_r <= '0;
    end else if (bit_ev && !ack_slot) begin
      shift_r <= rx_byte; // [RQ10]
    end
  end

  // Register pointer survives STOP so a bare read resumes from it
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      ptr_r <= '0;
    end else if (!start_ev && !stop_ev) begin
      if (byte_done && state_r == rtcs_pkg::ST_PTR) begin
        ptr_r <= rx_byte[5:0]; // [RQ13]
      end else if (byte_done && state_r == rtcs_pkg::ST_WDATA) begin
        ptr_r <= ptr_r + 6'h01; // [RQ15]
      end else if (ack_slot && state_r == rtcs_pkg::ST_RDATA) begin
        ptr_r <= ptr_r + 6'h01; // [RQ15]
      end
    end
  end

  // Write strobe one cycle after the byte, at the old pointer
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      wr_r <= '0;
    end else begin
      wr_r.en <= byte_done && !start_ev && !stop_ev && state_r == rtcs_pkg::ST_WDATA; // [RQ14]
      wr_r.addr <= ptr_r;
      wr_r.data <= rx_byte;
    end
  end

  // Read source: calendar register or RAM at the pointer
  assign ram_rd_addr = is_cal(ptr_r) ? 6'h00 : ptr_r - `RTCS_CAL_REGS;
  assign rd_byte = is_cal(ptr_r) ? cal_r[ptr_r[2:0]] : ram_q; // [RQ16]

  // Transmit shifter, loaded at the first low phase of each byte
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      tx_r <= '0;
    end else if (fall_ev && state_r == rtcs_pkg::ST_RDATA) begin
      if (cnt_r == 4'h0) begin
        tx_r <= {rd_byte[6:0], 1'b0}; // [RQ10]
      end else begin
        tx_r <= {tx_r[6:0], 1'b0};
      end
    end
  end

  // Data line drive, changed only after the clock is seen low
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      sda_oe_r <= 1'b0;
    end else if (start_ev || stop_ev) begin
      sda_oe_r <= 1'b0;
    end else if (fall_ev) begin // [RQ1] [RQ4]
      if (state_r == rtcs_pkg::ST_RDATA) begin
        if (cnt_r == 4'h0) begin
          sda_oe_r <= ~rd_byte[7];
        end else if (cnt_r == `RTCS_ACK_BIT) begin
          sda_oe_r <= 1'b0; // Release for the master's answer [RQ9]
        end else begin
          sda_oe_r <= ~tx_r[7];
        end
      end else begin
        // Pull low for the whole ninth pulse of an accepted byte
        sda_oe_r <= (cnt_r == `RTCS_ACK_BIT) && (state_r != rtcs_pkg::ST_IDLE); // [RQ7] [RQ12]
      end
    end
  end

  // Open-drain: the driven level is always low
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      sda_o_r <= 1'b0;
    end else begin
      sda_o_r <= 1'b0;
    end
  end

  // Busy from START to STOP; a repeated START keeps it set
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      busy_r <= 1'b0;
    end else if (start_ev) begin
      busy_r <= 1'b1; // [RQ17]
    end else if (stop_ev) begin
      busy_r <= 1'b0;
    end
  end

  assign SDA_O = sda_o_r;
  assign SDA_OE = sda_oe_r;
  assign BUS_BUSY = busy_r;

  // User RAM behind the calendar registers
  rtcs_ram u_ram (
    .clk(CLK_SYS),
    .wr_en(wr_r.en && !is_cal(wr_r.addr)),
    .wr_addr(wr_r.addr - `RTCS_CAL_REGS),
    .wr_data(wr_r.data),
    .rd_addr(ram_rd_addr),
    .rd_data(ram_q)
  ); // [RQ18]

  // Seconds prescaler, halted while the oscillator halt flag is set
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      sub_cnt_r <= '0;
    end else if (wr_r.en && wr_r.addr == {3'h0, `RTCS_REG_SEC}) begin
      sub_cnt_r <= '0; // Writing seconds restarts the second
    end else if (cal_r[`RTCS_REG_SEC][7]) begin
      sub_cnt_r <= sub_cnt_r;
    end else if (tick) begin
      sub_cnt_r <= '0;
    end else begin
      sub_cnt_r <= sub_cnt_r + 32'h1;
    end
  end

  assign tick = !cal_r[`RTCS_REG_SEC][7] && (sub_cnt_r == SEC_CYCLES - 32'h1);

  // Calendar carry chain for one tick
  always_comb begin
    logic [7:0] sec;
    logic [7:0] mins;
    logic [7:0] hr;
    logic [7:0] hr_out;
    logic [7:0] date;
    logic [7:0] mon;
    logic [7:0] last;
    logic c_min;
    logic c_hour;
    logic c_day;
    logic c_mon;
    logic c_year;
    hr = '0;
    hr_out = '0;
    c_day = 1'b0;
    for (int i = 0; i < `RTCS_CAL_COUNT; i++) begin
      cal_nxt[i] = cal_r[i];
    end
    sec = cal_r[`RTCS_REG_SEC] & `RTCS_SEC_MASK;
    mins = cal_r[`RTCS_REG_MIN] & `RTCS_MIN_MASK;
    date = cal_r[`RTCS_REG_DATE] & `RTCS_DATE_MASK;
    mon = cal_r[`RTCS_REG_MONTH] & `RTCS_MONTH_MASK;
    last = month_days(mon, cal_r[`RTCS_REG_YEAR]); // [RQ19]
    c_min = sec == `RTCS_MAX_SEC;
    c_hour = c_min && (mins == `RTCS_MAX_SEC);
    // Hour field: 12-hour mode keeps an AM/PM flag, 24-hour counts to 23
    if (cal_r[`RTCS_REG_HOUR][`RTCS_MODE12_BIT]) begin // [RQ20]
      hr = cal_r[`RTCS_REG_HOUR] & `RTCS_H12_MASK;
      c_day = (hr == `RTCS_H12_ELEVEN) && ((cal_r[`RTCS_REG_HOUR] & `RTCS_PM_MASK) != 8'h00);
      hr_out = cal_r[`RTCS_REG_HOUR] & ~`RTCS_H12_MASK;
      if (hr == `RTCS_H12_ELEVEN) begin
        hr_out = (hr_out ^ `RTCS_PM_MASK) | `RTCS_H12_TWELVE;
      end else if (hr == `RTCS_H12_TWELVE) begin
        hr_out = hr_out | `RTCS_BCD_ONE;
      end else begin
        hr_out = hr_out | bcd_inc(hr);
      end
    end else begin
      hr = cal_r[`RTCS_REG_HOUR] & `RTCS_H24_MASK;
      c_day = hr == `RTCS_MAX_H24;
      hr_out = (cal_r[`RTCS_REG_HOUR] & ~`RTCS_H24_MASK) |
               bcd_step(hr, `RTCS_MAX_H24, `RTCS_BCD_ZERO);
    end
    c_day = c_day && c_hour;
    c_mon = c_day && (date == last);
    c_year = c_mon && (mon == `RTCS_MAX_MONTH);
    cal_nxt[`RTCS_REG_SEC] = (cal_r[`RTCS_REG_SEC] & `RTCS_HALT_MASK) |
                             bcd_step(sec, `RTCS_MAX_SEC, `RTCS_BCD_ZERO); // [RQ18]
    if (c_min) begin
      cal_nxt[`RTCS_REG_MIN] = bcd_step(mins, `RTCS_MAX_SEC, `RTCS_BCD_ZERO);
    end
    if (c_hour) begin
      cal_nxt[`RTCS_REG_HOUR] = hr_out;
    end
    if (c_day) begin
      cal_nxt[`RTCS_REG_DAY] = bcd_step(cal_r[`RTCS_REG_DAY] & `RTCS_DAY_MASK,
                                        `RTCS_MAX_DAY, `RTCS_BCD_ONE);
      cal_nxt[`RTCS_REG_DATE] = bcd_step(date, last, `RTCS_BCD_ONE); // [RQ19]
    end
    if (c_mon) begin
      cal_nxt[`RTCS_REG_MONTH] = bcd_step(mon, `RTCS_MAX_MONTH, `RTCS_BCD_ONE);
    end
    if (c_year) begin
      cal_nxt[`RTCS_REG_YEAR] = bcd_step(cal_r[`RTCS_REG_YEAR], `RTCS_MAX_YEAR,
                                         `RTCS_BCD_ZERO);
    end
  end

  // Calendar registers; a bus write beats a tick in the same cycle
  // Mode changes do not convert the stored hour: software rewrites it
  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      for (int i = 0; i < `RTCS_CAL_COUNT; i++) begin
        cal_r[i] <= `RTCS_BCD_ZERO;
      end
      cal_r[`RTCS_REG_DAY] <= `RTCS_BCD_ONE;
      cal_r[`RTCS_REG_DATE] <= `RTCS_BCD_ONE;
      cal_r[`RTCS_REG_MONTH] <= `RTCS_BCD_ONE;
    end else if (wr_r.en && is_cal(wr_r.addr)) begin
      cal_r[wr_r.addr[2:0]] <= wr_r.data; // [RQ14]
    end else if (tick) begin
      for (int i = 0; i < `RTCS_CAL_COUNT; i++) begin
        cal_r[i] <= cal_nxt[i];
      end
    end
  end

endmodule

`default_nettype wire

// *** rtcs_slave_chk.sv ***
// Protocol assertions for the two-wire clock/calendar slave
`timescale 1ns/10ps
`default_nettype none

module rtcs_slave_chk #(
  parameter logic [6:0] DEV_ADDR = 7'h2a,
  parameter int unsigned SEC_CYCLES = 200
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RESETN,
  // Bus lines and status
  input wire logic SCL_CLK,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic BUS_BUSY
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  // Open drain, so a driven level is always low
  a_drive_low_only: assert property (SDA_OE |-> SDA_O == 1'b0)
    else $error("slave drives the data line high");
  // Data falling under a high clock opens a transfer
  a_start_busy: assert property ($fell(SDA_I) && SCL_CLK && $past(SCL_CLK) |-> ##[1:8] BUS_BUSY)
    else $error("start not seen");
  // Data rising under a high clock closes it
  a_stop_idle: assert property ($rose(SDA_I) && SCL_CLK && $past(SCL_CLK) |-> ##[1:8] !BUS_BUSY)
    else $error("stop not seen");
  a_busy_cause: assert property ($rose(BUS_BUSY) |-> SCL_CLK && !SDA_I)
    else $error("busy without start");
  a_idle_cause: assert property ($fell(BUS_BUSY) |-> SCL_CLK && SDA_I)
    else $error("busy dropped without stop");
  // Slave moves data only a few cycles after the clock falls
  a_change_low: assert property ($changed(SDA_OE) |-> !SCL_CLK && $past(SCL_CLK, 6))
    else $error("data driven outside the clock low phase");
  // A pulled-low bit stands until the next clock fall
  a_pull_holds: assert property ($rose(SDA_OE) |-> SDA_OE throughout (##[1:200] $fell(SCL_CLK)))
    else $error("pulled bit released early");
  // An idle bus is never pulled by the slave
  a_quiet_idle: assert property (!BUS_BUSY && $past(!BUS_BUSY) |-> !SDA_OE)
    else $error("data pulled while idle");
endmodule

bind rtcs_slave rtcs_slave_chk #(.DEV_ADDR(DEV_ADDR), .SEC_CYCLES(SEC_CYCLES)) chk (
  .CLK_SYS(CLK_SYS), .RESETN(RESETN), .SCL_CLK(SCL_CLK), .SDA_I(SDA_I),
  .SDA_O(SDA_O), .SDA_OE(SDA_OE), .BUS_BUSY(BUS_BUSY));
`default_nettype wire

// *** rtcs_master.sv ***
// Two-wire bus master model, paced off the system clock
`timescale 1ns/10ps
`default_nettype none

module rtcs_master #(
  parameter int QUARTER = 20
) (
  // Pacing clock
  input wire logic clk,
  // Resolved data wire, clock and data pull
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // Idle bus: clock high, data released to the pull-up
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One quarter bit; lines move just after a falling edge
  task automatic seq(input logic s, input logic l);
    scl = s;
    sda_low = l;
    repeat (QUARTER) @(negedge clk);
  endtask

  // Start or repeated start
  task automatic start();
    seq(1'b0, 1'b0);
    seq(1'b1, 1'b0);
    seq(1'b1, 1'b1);
    seq(1'b0, 1'b1);
  endtask

  // Stop, leaving the bus idle
  task automatic stop();
    seq(1'b0, 1'b1);
    seq(1'b1, 1'b1);
    seq(1'b1, 1'b0);
  endtask

  // Nine bits MSB first; a 1 releases the line so the other side may pull
  task automatic xfer(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      seq(1'b0, ~d[i]); // Data moves only with clock low
      seq(1'b1, ~d[i]); // Held through the high phase
      q[i] = sda;
      seq(1'b1, ~d[i]);
      seq(1'b0, ~d[i]);
    end
  endtask
endmodule
`default_nettype wire

// *** test_rtcs_slave.sv ***
// Self-checking bench for the two-wire clock/calendar slave
`timescale 1ns/10ps
`default_nettype none

module test_rtcs_slave;
  localparam logic [6:0] ADDR = 7'h2a; // Arbitrary value
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic scl;
  logic m_low;
  logic sda;
  logic sda_oe;
  logic bus_busy;
  logic [8:0] q;
  int miscompares = 0;
  int checks_done = 0;
  // Pointer, two bytes written, two bytes expected back
  logic [7:0] rows [4][5] = '{
    '{8'h08, 8'ha5, 8'h5a, 8'ha5, 8'h5a},
    '{8'h3f, 8'h3c, 8'h80, 8'h3c, 8'h80},
    '{8'hc9, 8'h01, 8'hfe, 8'h01, 8'hfe},
    '{8'h05, 8'h12, 8'h99, 8'h12, 8'h99}};

  always #10 clk_sys = ~clk_sys;
  // Open-drain wire with pull-up
  assign sda = ~(sda_oe | m_low);

  rtcs_slave #(.DEV_ADDR(ADDR), .SEC_CYCLES(200)) uut (
    .CLK_SYS(clk_sys), .RESETN(resetn), .SCL_CLK(scl), .SDA_I(sda),
    .SDA_O(), .SDA_OE(sda_oe), .BUS_BUSY(bus_busy));
  rtcs_master m (.clk(clk_sys), .sda(sda), .scl(scl), .sda_low(m_low));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d, miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Address byte plus direction, slave must pull the ninth bit
  task automatic adr(input logic rw);
    m.start();
    m.xfer({ADDR, rw, 1'b1}, q);
    check(8'(q[0]), 8'h00);
  endtask

  task automatic wr(input logic [7:0] b);
    m.xfer({b, 1'b1}, q);
    check(8'(q[0]), 8'h00);
  endtask

  task automatic rd(input logic [7:0] exp, input logic nack);
    m.xfer({8'hff, nack}, q); // Master acks all but the last
    check(q[8:1], exp);
  endtask

  task automatic setp(input logic [7:0] p);
    adr(1'b0);
    wr(p);
  endtask

  // Roll a halted calendar set to hr:59:59 on the 28th of February
  task automatic cal(input logic [7:0] yr, input logic [7:0] hr, input logic [7:0] hx,
                     input logic [7:0] dt, input logic [7:0] mo);
    setp(8'h00);
    wr(8'hd9);
    wr(8'h59);
    wr(hr);
    wr(8'h07);
    wr(8'h28);
    wr(8'h02);
    wr(yr);
    m.stop();
    setp(8'h00);
    wr(8'h59); // Restarts the count, tick lands well before the read
    m.stop();
    repeat (400) @(negedge clk_sys);
    setp(8'h02);
    adr(1'b1);
    rd(hx, 1'b0);
    rd(8'h01, 1'b0);
    rd(dt, 1'b0);
    rd(mo, 1'b1);
    m.stop();
    $display("calendar year %h done", yr);
  endtask

  initial begin
    repeat (5) @(negedge clk_sys);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    // Write each row, then read it back through a repeated start
    foreach (rows[i]) begin
      setp(rows[i][0]);
      wr(rows[i][1]);
      wr(rows[i][2]);
      m.stop();
      setp(rows[i][0]);
      adr(1'b1);
      check(8'(bus_busy), 8'h01);
      rd(rows[i][3], 1'b0);
      rd(rows[i][4], 1'b1);
      m.stop();
      $display("row %0d done", i);
    end
    // Second reset in mid-run, then calendar reset values
    resetn = 1'b0;
    repeat (5) @(negedge clk_sys);
    check(8'({sda_oe, bus_busy}), 8'h00);
    resetn = 1'b1;
    repeat (4) @(negedge clk_sys);
    setp(8'h03);
    adr(1'b1);
    rd(8'h01, 1'b0);
    rd(8'h01, 1'b0);
    rd(8'h01, 1'b0);
    rd(8'h00, 1'b1);
    m.stop();
    $display("reset values done");
    // Foreign address: no pull, later bytes ignored too
    m.start();
    m.xfer({ADDR ^ 7'h01, 1'b0, 1'b1}, q);
    check(8'(q[0]), 8'h01);
    m.xfer({8'h08, 1'b1}, q);
    check(8'(q[0]), 8'h01);
    m.stop();
    $display("foreign address done");
    // Refused last byte releases the line; pointer still advances
    setp(8'h10);
    wr(8'h11);
    wr(8'h22);
    wr(8'h33);
    m.stop();
    setp(8'h10);
    adr(1'b1);
    rd(8'h11, 1'b0);
    rd(8'h22, 1'b1);
    rd(8'hff, 1'b1);
    m.stop();
    adr(1'b1);
    rd(8'h33, 1'b1);
    m.stop();
    $display("refused read done");
    cal(8'h01, 8'h23, 8'h00, 8'h01, 8'h03);
    cal(8'h04, 8'h23, 8'h00, 8'h29, 8'h02);
    // 12-hour mode: 11 PM rolls to 12 AM and carries the date
    cal(8'h01, 8'h71, 8'h52, 8'h01, 8'h03);
    results();
  end

  // Watchdog past the expected run of about 88k cycles
  initial begin
    #1960000;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
